// ==== logic/svm_ctrl.sv ====
// The AXI4-Lite interface to the registers was chosen for this implementation.
module svm_ctrl #(
  parameter int unsigned DLY_250_CYC = svm_pkg::SVM_CYC_250
) (
  input  wire logic                        core_clk,
  input  wire logic                        sys_rst,
  // Analogue comparator result and programmed default
  input  wire logic                        monitored_input,
  input  wire logic [1:0]                  otp_threshold_sel,
  // Analogue and system side
  output logic [1:0]                       threshold_sel,
  output logic                             supply_ok_status,
  output logic                             switch_off_req,
  output logic                             irq,
  // AXI4-Lite slave
  input  wire logic [svm_pkg::SVM_AW-1:0]  s_axi_awaddr,
  input  wire logic [2:0]                  s_axi_awprot,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [svm_pkg::SVM_DW-1:0]  s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [svm_pkg::SVM_AW-1:0]  s_axi_araddr,
  input  wire logic [2:0]                  s_axi_arprot,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [svm_pkg::SVM_DW-1:0]       s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready
);
  import svm_pkg::*;

  svm_state_t r_q;
  svm_state_t r_d;

  // Cycle counts at the width of the counter
  localparam logic [SVM_CW-1:0] CNT_100 = SVM_CW'(SVM_CYC_100 - 1);
  logic [SVM_CW-1:0]           cnt_250;
  assign cnt_250 = SVM_CW'(DLY_250_CYC - 1);

  // Handshake outputs are plain decodes of held state
  assign s_axi_awready = !r_q.aw_have && !r_q.bvalid;
  assign s_axi_wready  = !r_q.w_have && !r_q.bvalid;
  assign s_axi_arready = !r_q.rvalid;
  assign s_axi_bvalid  = r_q.bvalid;
  assign s_axi_bresp   = r_q.bresp;
  assign s_axi_rvalid  = r_q.rvalid;
  assign s_axi_rdata   = r_q.rdata;
  assign s_axi_rresp   = r_q.rresp;

  // Outputs to the analogue side and the system
  assign threshold_sel    = r_q.sel;
  assign supply_ok_status = r_q.ok;
  assign switch_off_req   = r_q.off_en && !r_q.ok;
  assign irq              = |(r_q.ist & r_q.ien);

  // Register image of the monitor register
  logic [7:0] mon_img;
  always_comb begin
    mon_img = 8'h00;
    mon_img[SVM_B_SEL +: 2] = r_q.sel;
    mon_img[SVM_B_STAT]     = r_q.ok;
    mon_img[SVM_B_MASK]     = r_q.off_en;
    mon_img[SVM_B_DLY +: 2] = r_q.dly;
  end

  // Write decode of the held address, read decode of the live one
  logic [9:0] w_idx;
  logic [9:0] r_idx;
  logic       do_wr;
  logic       do_rd;
  assign w_idx = r_q.aw_addr[11:2];
  assign r_idx = s_axi_araddr[11:2];
  assign do_wr = r_q.aw_have && r_q.w_have && !r_q.bvalid;
  assign do_rd = s_axi_arvalid && !r_q.rvalid;

  // Next state of the whole block
  always_comb begin
    logic [SVM_NEV-1:0] ev;
    logic [SVM_NEV-1:0] clr;
    logic               cmp;
    logic               ok_n;
    ev   = '0;
    clr  = '0;
    cmp  = r_q.cmp_s2;
    ok_n = r_q.ok;
    r_d  = r_q;

    // Two-stage synchronisers; first stage feeds only the second
    r_d.cmp_s1 = monitored_input;
    r_d.cmp_s2 = r_q.cmp_s1;
    r_d.otp_s1 = otp_threshold_sel;
    r_d.otp_s2 = r_q.otp_s1;

    // Programmed default is taken once the synchroniser has settled
    if (r_q.otp_wait != 2'h0) begin
      r_d.otp_wait = r_q.otp_wait - 2'h1;
    end else if (r_q.otp_ld) begin
      r_d.sel    = r_q.otp_s2;
      r_d.otp_ld = 1'b0;
    end

    // Status tracker: delay only on the way down
    case (r_q.dst)
      SVM_ST_HIGH: begin
        if (!cmp) begin
          ev[SVM_EV_FALL] = 1'b1;
          if (r_q.dly == SVM_DLY_100) begin
            r_d.dst = SVM_ST_HOLD;
            r_d.cnt = CNT_100;
          end else if (r_q.dly == SVM_DLY_250) begin
            r_d.dst = SVM_ST_HOLD;
            r_d.cnt = cnt_250;
          end else begin
            // Codes 00 and 01 drop at once
            r_d.dst = SVM_ST_LOW;
          end
        end
      end
      SVM_ST_HOLD: begin
        if (cmp) begin
          // Recovery inside the window cancels the drop
          r_d.dst = SVM_ST_HIGH;
        end else if (r_q.cnt == '0) begin
          r_d.dst = SVM_ST_LOW;
        end else begin
          r_d.cnt = r_q.cnt - SVM_CW'(1);
        end
      end
      SVM_ST_LOW: begin
        if (cmp) begin
          ev[SVM_EV_RISE] = 1'b1;
          r_d.dst = SVM_ST_HIGH;
        end
      end
      default: begin
        r_d.dst = SVM_ST_LOW;
      end
    endcase

    // Status bit follows the tracker state
    ok_n     = (r_d.dst != SVM_ST_LOW);
    r_d.ok   = ok_n;
    if (r_q.ok && !ok_n && r_q.off_en) begin
      ev[SVM_EV_OFF] = 1'b1;
    end

    // Address and data channels are taken in either order
    if (s_axi_awvalid && !r_q.aw_have && !r_q.bvalid) begin
      r_d.aw_have = 1'b1;
      r_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r_q.w_have && !r_q.bvalid) begin
      r_d.w_have = 1'b1;
      r_d.wdata  = s_axi_wdata[7:0];
      r_d.wstrb0 = s_axi_wstrb[0];
    end

    // Write takes effect once both halves are held
    if (do_wr) begin
      r_d.aw_have = 1'b0;
      r_d.w_have  = 1'b0;
      r_d.bvalid  = 1'b1;
      r_d.bresp   = SVM_RESP_OKAY;
      case (w_idx)
        SVM_IDX_MON: begin
          // Status and spare bits ignore writes
          if (r_q.wstrb0) begin
            r_d.sel    = r_q.wdata[SVM_B_SEL +: 2];
            r_d.off_en = r_q.wdata[SVM_B_MASK];
            r_d.dly    = r_q.wdata[SVM_B_DLY +: 2];
          end
        end
        SVM_IDX_ICLR: begin
          if (r_q.wstrb0) begin
            clr = r_q.wdata[SVM_NEV-1:0];
          end
        end
        SVM_IDX_IEN: begin
          if (r_q.wstrb0) begin
            r_d.ien = r_q.wdata[SVM_NEV-1:0];
          end
        end
        SVM_IDX_IST: begin
          // Read-only: accepted, no effect
          r_d.bresp = SVM_RESP_OKAY;
        end
        default: begin
          r_d.bresp = SVM_RESP_SLVERR;
        end
      endcase
    end
    if (r_q.bvalid && s_axi_bready) begin
      r_d.bvalid = 1'b0;
    end

    // Sticky events; a new event beats a clear in the same cycle
    for (int i = 0; i < SVM_NEV; i++) begin
      r_d.ist[i] = (r_q.ist[i] && !clr[i]) || ev[i];
    end

    // Read data is captured at the address handshake
    if (do_rd) begin
      r_d.rvalid = 1'b1;
      r_d.rresp  = SVM_RESP_OKAY;
      r_d.rdata  = '0;
      case (r_idx)
        SVM_IDX_MON: begin
          r_d.rdata[7:0] = mon_img;
        end
        SVM_IDX_IST: begin
          r_d.rdata[SVM_NEV-1:0] = r_q.ist;
        end
        SVM_IDX_IEN: begin
          r_d.rdata[SVM_NEV-1:0] = r_q.ien;
        end
        SVM_IDX_ICLR: begin
          // Write-only register reads as zero
          r_d.rresp = SVM_RESP_OKAY;
        end
        default: begin
          r_d.rresp = SVM_RESP_SLVERR;
        end
      endcase
    end else if (r_q.rvalid && s_axi_rready) begin
      r_d.rvalid = 1'b0;
    end

    // Synchronous reset overrides everything with constants
    if (sys_rst) begin
      r_d          = '0;
      r_d.dst      = SVM_ST_LOW;
      r_d.sel      = SVM_RST_SEL;
      r_d.dly      = SVM_RST_DLY;
      r_d.off_en   = SVM_RST_OFF_EN;
      r_d.otp_wait = SVM_OTP_SETTLE;
      r_d.otp_ld   = 1'b1;
    end
  end

  // Single state register
  always_ff @(posedge core_clk) begin
    r_q <= r_d;
  end

endmodule

// ==== pkg/svm_pkg.sv ====
package svm_pkg;

  // Bus geometry
  localparam int unsigned SVM_AW = 12;
  localparam int unsigned SVM_DW = 32;

  // Register indices; byte address is four times the index
  localparam logic [9:0] SVM_IDX_MON  = 10'h046;
  localparam logic [9:0] SVM_IDX_IST  = 10'h060;
  localparam logic [9:0] SVM_IDX_ICLR = 10'h061;
  localparam logic [9:0] SVM_IDX_IEN  = 10'h062;

  // Field positions in the supply_monitor_control register
  localparam int unsigned SVM_B_SEL  = 0;
  localparam int unsigned SVM_B_STAT = 2;
  localparam int unsigned SVM_B_MASK = 4;
  localparam int unsigned SVM_B_DLY  = 5;

  // Values after reset
  localparam logic [1:0] SVM_RST_DLY    = 2'h2;
  localparam logic       SVM_RST_OFF_EN = 1'h1;
  localparam logic [1:0] SVM_RST_SEL    = 2'h0;
  localparam logic [1:0] SVM_OTP_SETTLE = 2'h2;

  // Falling delay codes
  localparam logic [1:0] SVM_DLY_NONE  = 2'h0;
  localparam logic [1:0] SVM_DLY_UNDEF = 2'h1;
  localparam logic [1:0] SVM_DLY_100   = 2'h2;
  localparam logic [1:0] SVM_DLY_250   = 2'h3;

  // Times and cycle counts, least times rounded up
  localparam int unsigned SVM_CLK_NS  = 25;
  localparam int unsigned SVM_T100_NS = 100000;
  localparam int unsigned SVM_T250_NS = 250000;
  localparam int unsigned SVM_CYC_100 =
    (SVM_T100_NS + SVM_CLK_NS - 1) / SVM_CLK_NS;
  localparam int unsigned SVM_CYC_250 =
    (SVM_T250_NS + SVM_CLK_NS - 1) / SVM_CLK_NS;
  localparam int unsigned SVM_CW = 14;

  // Interrupt event bits
  localparam int unsigned SVM_NEV     = 3;
  localparam int unsigned SVM_EV_FALL = 0;
  localparam int unsigned SVM_EV_RISE = 1;
  localparam int unsigned SVM_EV_OFF  = 2;

  // Bus responses
  localparam logic [1:0] SVM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SVM_RESP_SLVERR = 2'h2;

  // Supply status tracker states
  typedef enum logic [1:0] {
    SVM_ST_LOW  = 2'b00,
    SVM_ST_HIGH = 2'b01,
    SVM_ST_HOLD = 2'b10
  } svm_dst_t;

  // Whole state of the block
  typedef struct packed {
    logic                 cmp_s1;
    logic                 cmp_s2;
    logic [1:0]           otp_s1;
    logic [1:0]           otp_s2;
    logic [1:0]           otp_wait;
    logic                 otp_ld;
    svm_dst_t             dst;
    logic [SVM_CW-1:0]    cnt;
    logic                 ok;
    logic [1:0]           sel;
    logic [1:0]           dly;
    logic                 off_en;
    logic [SVM_NEV-1:0]   ist;
    logic [SVM_NEV-1:0]   ien;
    logic                 aw_have;
    logic [SVM_AW-1:0]    aw_addr;
    logic                 w_have;
    logic [7:0]           wdata;
    logic                 wstrb0;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [SVM_DW-1:0]    rdata;
    logic [1:0]           rresp;
  } svm_state_t;

endpackage

// ==== tb/svm_ctrl_asserts.sv ====
module svm_ctrl_asserts #(
  parameter int unsigned DLY_250_CYC = 20
) (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        monitored_input,
  input wire logic [1:0]  otp_threshold_sel,
  input wire logic [1:0]  threshold_sel,
  input wire logic        supply_ok_status,
  input wire logic        switch_off_req,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready
);
  // Longest legal hold plus sync slack
  localparam int LIM = ((DLY_250_CYC > 4000) ? DLY_250_CYC : 4000) + 8;
  logic [15:0] lo_q;
  logic [15:0] lo_d;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Run length of a low comparator, saturating
  always_comb lo_d = monitored_input ? 16'h0 : lo_q + {15'h0, ~&lo_q};
  always_ff @(posedge core_clk) lo_q <= sys_rst ? 16'h0 : lo_d;
  // Monitor register read and its answer
  sequence s_mon_rd;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h118;
  endsequence
  sequence s_rd_ret;
    s_axi_rvalid && s_axi_rdata[31:8] == 24'h0 && !s_axi_rdata[7]
      && !s_axi_rdata[3];
  endsequence
  a_reserved_bit_zero: assert property (s_mon_rd |=> s_rd_ret)
    else $error("reserved bits not zero");
  a_off_req_low: assert property (
    switch_off_req |-> !supply_ok_status)
    else $error("switch-off while status high");
  a_rise_prompt: assert property (
    monitored_input [*4] |=> supply_ok_status)
    else $error("rising status delayed");
  a_fall_bounded: assert property (lo_q >= LIM |-> !supply_ok_status)
    else $error("status held too long");
  a_sel_reload: assert property (
    $fell(sys_rst) |-> ##[2:4] threshold_sel == otp_threshold_sel)
    else $error("threshold default not loaded");
  a_b_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
endmodule

bind svm_ctrl svm_ctrl_asserts #(.DLY_250_CYC(DLY_250_CYC)) u_chk (
  .core_clk, .sys_rst, .monitored_input, .otp_threshold_sel,
  .threshold_sel, .supply_ok_status, .switch_off_req, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready);

// ==== tb/tb.sv ====
module tb import svm_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int D250 = 20;
  localparam logic [11:0] A_MON = {SVM_IDX_MON, 2'h0};
  localparam logic [11:0] A_IST = {SVM_IDX_IST, 2'h0};
  localparam logic [11:0] A_CLR = {SVM_IDX_ICLR, 2'h0};
  localparam logic [11:0] A_IEN = {SVM_IDX_IEN, 2'h0};
  logic        core_clk = 1'h0, sys_rst = 1'h1, monitored_input = 1'h1;
  logic [1:0]  otp_threshold_sel = 2'h3, threshold_sel;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        supply_ok_status, switch_off_req, irq;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int          n_mismatch = 0, n_compared = 0;

  always #12.5 core_clk = ~core_clk;

  // Short 250 us count keeps the run brief
  svm_ctrl #(.DLY_250_CYC(D250)) uut (.core_clk, .sys_rst,
    .monitored_input, .otp_threshold_sel, .threshold_sel,
    .supply_ok_status, .switch_off_req, .irq, .s_axi_awaddr,
    .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string m);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Readies are decodes of held state, so the negedge view holds at the edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    bit ta, tw, da, dw, bv;
    logic [1:0] r;
    {da, dw, bv} = 3'h0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(da && dw)) begin
      @(negedge core_clk);
      ta = s_axi_awready && !da;
      tw = s_axi_wready && !dw;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      da |= ta;
      dw |= tw;
    end
    while (!bv) begin
      @(negedge core_clk);
      bv = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge core_clk);
    end
    s_axi_bready <= 1'h0;
    chk(r, er, "write resp");
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    bit t, v;
    logic [31:0] d;
    logic [1:0] r;
    {t, v} = 2'h0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!t) begin
      @(negedge core_clk);
      t = s_axi_arready;
      @(posedge core_clk);
    end
    s_axi_arvalid <= 1'h0;
    while (!v) begin
      @(negedge core_clk);
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge core_clk);
    end
    s_axi_rready <= 1'h0;
    chk(d, e, "read data");
    chk(r, er, "read resp");
  endtask

  task automatic t_reset();
    rd(A_MON, 32'h57, SVM_RESP_OKAY);
    chk(threshold_sel, otp_threshold_sel, "otp threshold");
    chk(supply_ok_status, 1'h1, "status high");
    chk(irq, 1'h0, "irq after reset");
  endtask

  task automatic t_fields();
    wr(A_MON, 32'hff, SVM_RESP_OKAY);
    rd(A_MON, 32'h77, SVM_RESP_OKAY);
    // Lane 0 disabled: the write is answered but changes nothing
    s_axi_wstrb <= 4'h0;
    wr(A_MON, 32'h00, SVM_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(A_MON, 32'h77, SVM_RESP_OKAY);
    // Status is read-only; only the rise seen after reset is held
    wr(A_IST, 32'h7, SVM_RESP_OKAY);
    rd(A_IST, 32'h2, SVM_RESP_OKAY);
    rd(A_CLR, 32'h0, SVM_RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      wr(A_MON, 32'h10 | i, SVM_RESP_OKAY);
      chk(threshold_sel, i, "threshold code");
    end
    wr(12'h200, 32'hff, SVM_RESP_SLVERR);
    rd(12'h200, 32'h0, SVM_RESP_SLVERR);
  endtask

  // Falling input per delay code, then recovery and interrupt upkeep
  task automatic t_fall(input logic [1:0] code, input logic mask);
    int n, d;
    bit fi, ko;
    d = (code == 2'h3) ? D250 : (code == 2'h2) ? 4000 : 0;
    {n, fi, ko} = 0;
    wr(A_MON, {25'h0, code, mask, 4'h0}, SVM_RESP_OKAY);
    wr(A_CLR, 32'h7, SVM_RESP_OKAY);
    wr(A_IEN, 32'h7, SVM_RESP_OKAY);
    @(posedge core_clk);
    monitored_input <= 1'h0;
    while (supply_ok_status !== 1'h0 && n < 5000) begin
      @(posedge core_clk);
      #1;
      n++;
      if (irq && !fi) begin
        fi = 1'h1;
        ko = supply_ok_status;
      end
    end
    chk(n >= d + 2 && n <= d + 5, 1'h1, "fall delay");
    chk(ko, d != 0, "irq before drop");
    chk(irq, 1'h1, "irq raised");
    chk(switch_off_req, mask, "switch-off");
    rd(A_IST, {29'h0, mask, 2'h1}, SVM_RESP_OKAY);
    @(posedge core_clk);
    monitored_input <= 1'h1;
    repeat (5) @(posedge core_clk);
    #1;
    chk(supply_ok_status, 1'h1, "rise");
    wr(A_IEN, 32'h0, SVM_RESP_OKAY);
    #1;
    chk(irq, 1'h0, "masked");
    wr(A_CLR, 32'h7, SVM_RESP_OKAY);
    wr(A_IEN, 32'h7, SVM_RESP_OKAY);
    #1;
    chk(irq, 1'h0, "cleared");
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'h0;
    repeat (8) @(posedge core_clk);
    t_reset();
    t_fields();
    t_fall(2'h0, 1'h1);
    t_fall(2'h1, 1'h0);
    t_fall(2'h2, 1'h1);
    t_fall(2'h3, 1'h0);
    close_out();
  end

  // Watchdog well beyond the longest hold
  initial begin
    repeat (30000) @(posedge core_clk);
    n_mismatch++;
    $display("BAD %0t timeout", $time);
    close_out();
  end
endmodule
